// ---- verilog/fsps_pkg.sv ----
package fsps_pkg;
  // flash geometry
  localparam int ROW_INSTR      = 64;
  localparam int ROW_BYTES      = 192;
  localparam int PAGE_ROWS      = 8;
  localparam int PAGE_INSTR     = 512;
  localparam int PAGE_BYTES     = 1536;
  localparam int INSTR_W        = 24;
  localparam int ADDR_W         = 24;
  // control register layout
  localparam int CTL_START_BIT  = 15;
  localparam int CTL_W          = 16;
  localparam logic [1:0] OP_ROW_WRITE  = 2'h1;
  localparam logic [1:0] OP_WORD_WRITE = 2'h2;
  localparam logic [1:0] OP_PAGE_ERASE = 2'h3;
  localparam logic [1:0] OP_NONE       = 2'h0;
  localparam int CTL_OP_LSB     = 0;
  // unlock key values
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // operation durations in oscillator cycles
  localparam int ROW_WRITE_OSC  = 11064;
  localparam int WORD_WRITE_OSC = 11064;
  localparam int PAGE_ERASE_OSC = 11064;
  // table write duration in core cycles
  localparam int TBLWR_CYCLES   = 2;
  typedef enum logic [1:0] {
    FSPS_IDLE,
    FSPS_BUSY,
    FSPS_DONE
  } fsps_state_t;
endpackage : fsps_pkg

// ---- verilog/fsps_seq.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - flash rows hold 64 instructions, 192 bytes each.
// - erase removes one page of eight rows, 512 instructions.
// - program either one whole row or one instruction word.
// - pages align on 1536 bytes, rows on 192 bytes.
// - holding buffer keeps up to 64 pending instructions.
// - each table write is a two-cycle single-word buffer write.
// - each row needs its own programming cycle.
// - core stalls while erase or program runs, released on completion.
// - start bit 15 begins the operation; hardware clears it when done.
// - key register is write-only and only gates flash operations.
// - control register selects erase/program kind and triggers start.
// - duration counted in fast RC oscillator ticks; row write 11064.
module fsps_seq #(
  parameter int ROW_WRITE_TICKS = fsps_pkg::ROW_WRITE_OSC,
  parameter int PAGE_ERASE_TICKS = fsps_pkg::PAGE_ERASE_OSC,
  parameter int WORD_WRITE_TICKS = fsps_pkg::WORD_WRITE_OSC
) (
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  input  wire logic                         osc_tick,
  input  wire logic                         ctl_wr,
  input  wire logic [fsps_pkg::CTL_W-1:0]   ctl_wdata,
  output logic      [fsps_pkg::CTL_W-1:0]   flash_control_reg,
  input  wire logic                         key_wr,
  input  wire logic [7:0]                   key_wdata,
  input  wire logic                         tbl_wr,
  input  wire logic                         tbl_high,
  input  wire logic [fsps_pkg::ADDR_W-1:0]  tbl_addr,
  input  wire logic [15:0]                  tbl_wdata,
  output logic                              core_stall,
  output logic                              flash_op_valid,
  output logic      [1:0]                   flash_op,
  output logic      [fsps_pkg::ADDR_W-1:0]  flash_addr,
  output logic      [fsps_pkg::INSTR_W-1:0] flash_word,
  output logic                              flash_word_we,
  output logic      [5:0]                   flash_word_idx,
  output logic                              busy
);
  localparam int IDX_W = $clog2(fsps_pkg::ROW_INSTR);
  localparam int AW    = fsps_pkg::ADDR_W;

  fsps_pkg::fsps_state_t state;
  logic [1:0]  key_stage;
  logic [13:0] tick_cnt;
  logic [13:0] tick_limit;
  logic [1:0]  op_sel;
  logic        tbl_hold;
  logic [fsps_pkg::ADDR_W-1:0] op_addr;
  logic [IDX_W-1:0] drain_idx;
  logic        drain_end;
  logic        start_req;
  // holding buffer, one word per instruction
  logic [fsps_pkg::INSTR_W-1:0] hold_buf [fsps_pkg::ROW_INSTR];

  assign start_req = ctl_wr && ctl_wdata[fsps_pkg::CTL_START_BIT]
                     && !flash_control_reg[fsps_pkg::CTL_START_BIT];

  // key sequence tracker; any other write between breaks it
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      key_stage <= 2'h0;
    end else if (key_wr) begin
      if (key_wdata == fsps_pkg::KEY_FIRST) begin
        key_stage <= 2'h1;
      end else if (key_stage == 2'h1 && key_wdata == fsps_pkg::KEY_SECOND)
      begin
        key_stage <= 2'h2;
      end else begin
        key_stage <= 2'h0;
      end
    end else if (ctl_wr || tbl_wr) begin
      key_stage <= 2'h0;
    end
  end

  // holding buffer fill; low half then high byte per word
  always_ff @(posedge ref_clk) begin
    if (tbl_wr && !busy) begin
      if (tbl_high) begin
        hold_buf[tbl_addr[IDX_W:1]][23:16] <= tbl_wdata[7:0];
      end else begin
        hold_buf[tbl_addr[IDX_W:1]][15:0] <= tbl_wdata;
      end
    end
  end

  // table write takes two cycles: one stall cycle after the write
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tbl_hold <= 1'b0;
    end else begin
      tbl_hold <= tbl_wr && !tbl_hold;
    end
  end

  // control register; start bit only sets after the key
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flash_control_reg <= '0;
    end else if (state == fsps_pkg::FSPS_DONE) begin
      flash_control_reg[fsps_pkg::CTL_START_BIT] <= 1'b0;
    end else if (ctl_wr && state == fsps_pkg::FSPS_IDLE) begin
      flash_control_reg[fsps_pkg::CTL_START_BIT-1:0] <=
        ctl_wdata[fsps_pkg::CTL_START_BIT-1:0];
      flash_control_reg[fsps_pkg::CTL_START_BIT] <=
        start_req && key_stage == 2'h2;
    end
  end

  // duration per operation kind
  always_comb begin
    case (op_sel)
      fsps_pkg::OP_PAGE_ERASE: tick_limit = 14'(PAGE_ERASE_TICKS);
      fsps_pkg::OP_WORD_WRITE: tick_limit = 14'(WORD_WRITE_TICKS);
      default:                 tick_limit = 14'(ROW_WRITE_TICKS);
    endcase
  end

  // sequencer: idle, busy counting oscillator ticks, done
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state    <= fsps_pkg::FSPS_IDLE;
      tick_cnt <= '0;
      op_sel   <= fsps_pkg::OP_NONE;
      op_addr  <= '0;
    end else begin
      case (state)
        fsps_pkg::FSPS_IDLE: begin
          tick_cnt <= '0;
          if (flash_control_reg[fsps_pkg::CTL_START_BIT]) begin
            state  <= fsps_pkg::FSPS_BUSY;
            op_sel <= flash_control_reg[fsps_pkg::CTL_OP_LSB +: 2];
            // align target to page or row boundary
            if (flash_control_reg[1:0] == fsps_pkg::OP_PAGE_ERASE) begin
              op_addr <= AW'(tbl_addr - tbl_addr % fsps_pkg::PAGE_BYTES);
            end else if (flash_control_reg[1:0] == fsps_pkg::OP_ROW_WRITE)
            begin
              op_addr <= AW'(tbl_addr - tbl_addr % fsps_pkg::ROW_BYTES);
            end else begin
              op_addr <= tbl_addr;
            end
          end
        end
        fsps_pkg::FSPS_BUSY: begin
          if (osc_tick) begin
            tick_cnt <= tick_cnt + 14'h0001;
          end
          if (tick_cnt == tick_limit) begin
            state <= fsps_pkg::FSPS_DONE;
          end
        end
        fsps_pkg::FSPS_DONE: state <= fsps_pkg::FSPS_IDLE;
        default: state <= fsps_pkg::FSPS_IDLE;
      endcase
    end
  end

  // buffer drain walks a row once while busy; a word write takes one slot
  // so the array port fires exactly once per buffered word
  always_ff @(posedge ref_clk) begin
    if (!reset_n || state != fsps_pkg::FSPS_BUSY) begin
      drain_idx <= '0;
      drain_end <= 1'b0;
    end else if (!drain_end && (op_sel == fsps_pkg::OP_ROW_WRITE
                                || op_sel == fsps_pkg::OP_WORD_WRITE)) begin
      drain_idx <= drain_idx + 1'b1;
      drain_end <= op_sel == fsps_pkg::OP_WORD_WRITE
                   || drain_idx == IDX_W'(fsps_pkg::ROW_INSTR - 1);
    end
  end

  // array write port; the array itself lives outside
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flash_word     <= '0;
      flash_word_we  <= 1'b0;
      flash_word_idx <= '0;
    end else begin
      flash_word_we  <= state == fsps_pkg::FSPS_BUSY && !drain_end
                        && (op_sel == fsps_pkg::OP_ROW_WRITE
                            || op_sel == fsps_pkg::OP_WORD_WRITE);
      flash_word_idx <= (op_sel == fsps_pkg::OP_WORD_WRITE)
                        ? op_addr[IDX_W:1] : drain_idx;
      flash_word     <= hold_buf[(op_sel == fsps_pkg::OP_WORD_WRITE)
                        ? op_addr[IDX_W:1] : drain_idx];
    end
  end

  assign busy           = state != fsps_pkg::FSPS_IDLE;
  assign core_stall     = busy || tbl_hold;
  assign flash_op_valid = state == fsps_pkg::FSPS_BUSY;
  assign flash_op       = op_sel;
  assign flash_addr     = op_addr;

  a_start_needs_key: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(flash_control_reg[fsps_pkg::CTL_START_BIT]) |->
      $past(key_stage) == 2'h2)
    else $error("start bit set without unlock");
  a_stall_while_op: assert property (@(posedge ref_clk) disable iff (!reset_n)
    flash_op_valid |-> core_stall)
    else $error("core not stalled during operation");
  a_start_self_clear: assert property (@(posedge ref_clk)
    disable iff (!reset_n)
    state == fsps_pkg::FSPS_DONE |=>
      !flash_control_reg[fsps_pkg::CTL_START_BIT])
    else $error("start bit not cleared on completion");
  a_key_order: assert property (@(posedge ref_clk) disable iff (!reset_n)
    key_wr && key_wdata == fsps_pkg::KEY_SECOND && key_stage != 2'h1
      |=> key_stage == 2'h0)
    else $error("key accepted out of order");
  a_tbl_two_cyc: assert property (@(posedge ref_clk) disable iff (!reset_n)
    tbl_wr && !tbl_hold |=> core_stall)
    else $error("table write not two cycles");
  a_busy_ends: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state == fsps_pkg::FSPS_BUSY && tick_cnt == tick_limit
      |=> state == fsps_pkg::FSPS_DONE ##1 !busy)
    else $error("operation did not finish on count");
  a_row_align: assert property (@(posedge ref_clk) disable iff (!reset_n)
    flash_op_valid && op_sel == fsps_pkg::OP_ROW_WRITE
      |-> op_addr % fsps_pkg::ROW_BYTES == 0)
    else $error("row target misaligned");
  a_page_align: assert property (@(posedge ref_clk) disable iff (!reset_n)
    flash_op_valid && op_sel == fsps_pkg::OP_PAGE_ERASE
      |-> op_addr % fsps_pkg::PAGE_BYTES == 0)
    else $error("page target misaligned");
  a_word_once: assert property (@(posedge ref_clk) disable iff (!reset_n)
    flash_word_we && op_sel == fsps_pkg::OP_WORD_WRITE
      |=> !flash_word_we)
    else $error("word write fired twice");
endmodule : fsps_seq

// ---- tb/fsps_core_model.sv ----
`timescale 1ns/1ps
// core side: register writes, table writes and the oscillator tick
module fsps_core_model (
  input  wire logic        ref_clk,
  output logic             osc_tick,
  output logic             key_wr,
  output logic [7:0]       key_wdata,
  output logic             ctl_wr,
  output logic [15:0]      ctl_wdata,
  output logic             tbl_wr,
  output logic             tbl_high,
  output logic [23:0]      tbl_addr,
  output logic [15:0]      tbl_wdata
);
  logic [1:0] div;

  // everything idle at time zero
  initial begin
    {div, osc_tick, key_wr, key_wdata, ctl_wr, ctl_wdata} = '0;
    {tbl_wr, tbl_high, tbl_addr, tbl_wdata} = '0;
  end

  // oscillator slower than the core: one tick every third cycle
  always @(posedge ref_clk) begin
    div      <= (div == 2'h2) ? 2'h0 : div + 2'h1;
    osc_tick <= (div == 2'h2);
  end

  // two key writes back to back; data inverted once released
  task automatic unlock(input logic [7:0] k0, input logic [7:0] k1);
    key_wr    <= 1'h1;
    key_wdata <= k0;
    @(posedge ref_clk);
    key_wdata <= k1;
    @(posedge ref_clk);
    key_wr    <= 1'h0;
    key_wdata <= ~k1;
  endtask : unlock

  // table pointer doubles as the start target address
  task automatic ctl_write(input logic [15:0] d, input logic [23:0] a);
    ctl_wr    <= 1'h1;
    ctl_wdata <= d;
    tbl_addr  <= a;
    @(posedge ref_clk);
    ctl_wr    <= 1'h0;
    ctl_wdata <= ~d;
  endtask : ctl_write

  // caller lets the stalled second cycle pass before the next one
  task automatic tbl_write(input logic h, input logic [23:0] a,
                           input logic [15:0] d);
    tbl_wr    <= 1'h1;
    tbl_high  <= h;
    tbl_addr  <= a;
    tbl_wdata <= d;
    @(posedge ref_clk);
    tbl_wr    <= 1'h0;
    tbl_wdata <= ~d;
  endtask : tbl_write
endmodule : fsps_core_model

// ---- tb/test_fsps_seq.sv ----
`timescale 1ns/1ps
module test_fsps_seq;
  logic        ref_clk, reset_n, osc_tick, key_wr, ctl_wr, tbl_wr, tbl_high;
  logic        core_stall, flash_op_valid, flash_word_we, busy;
  logic [7:0]  key_wdata;
  logic [15:0] ctl_wdata, tbl_wdata, flash_control_reg;
  logic [23:0] tbl_addr, flash_addr, flash_word;
  logic [5:0]  flash_word_idx;
  logic [1:0]  flash_op;
  int          num_errors = 0, tests_run = 0, cycles = 0;

  fsps_core_model u_fsps_core_model (.ref_clk(ref_clk), .osc_tick(osc_tick),
    .key_wr(key_wr), .key_wdata(key_wdata), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata), .tbl_wr(tbl_wr), .tbl_high(tbl_high),
    .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata));
  // short counts, yet long enough for a 64-word row to drain while busy
  fsps_seq #(.ROW_WRITE_TICKS(24), .PAGE_ERASE_TICKS(24),
    .WORD_WRITE_TICKS(24)) u_fsps_seq (.ref_clk(ref_clk), .reset_n(reset_n),
    .osc_tick(osc_tick), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
    .flash_control_reg(flash_control_reg), .key_wr(key_wr),
    .key_wdata(key_wdata), .tbl_wr(tbl_wr), .tbl_high(tbl_high),
    .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata), .core_stall(core_stall),
    .flash_op_valid(flash_op_valid), .flash_op(flash_op),
    .flash_addr(flash_addr), .flash_word(flash_word),
    .flash_word_we(flash_word_we), .flash_word_idx(flash_word_idx),
    .busy(busy));

  // 50 ns period
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end

  // hang guard, well above the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic logic [23:0] exp_word(input logic [5:0] i);
    return {8'h40 + 8'(i), 16'h1000 + 16'(i) * 16'h0003};
  endfunction : exp_word

  // a start that must be ignored: bad key pair before the start write
  task automatic refused(input logic [7:0] k0, input logic [7:0] k1);
    u_fsps_core_model.unlock(k0, k1);
    u_fsps_core_model.ctl_write(16'h8001, 24'h00_0000);
    repeat (3) @(posedge ref_clk);
    #1 check({flash_control_reg[15], busy}, 2'h0);
    @(posedge ref_clk);
  endtask : refused

  // sequential low then high writes of one aligned 64-word group
  task automatic load_row(input logic [23:0] base);
    logic [23:0] w;
    for (int i = 0; i < 64; i++) begin
      w = exp_word(6'(i));
      for (int h = 0; h < 2; h++) begin
        u_fsps_core_model.tbl_write(h[0], base + 24'(2 * i),
          h ? {8'h00, w[23:16]} : w[15:0]);
        #1 check(core_stall, 1'h1);
        @(posedge ref_clk);
      end
    end
  endtask : load_row

  task automatic run_op(input logic [1:0] op, input logic [23:0] a,
                        input int unit, input int exp_we);
    int ticks;
    int wes;
    logic [5:0] idx;
    ticks = 0;
    wes = 0;
    u_fsps_core_model.unlock(8'h55, 8'hAA);
    u_fsps_core_model.ctl_write({1'h1, 13'h0000, op}, a);
    #1 check(flash_control_reg[15], 1'h1);
    @(posedge ref_clk);
    #1 check({busy, core_stall, flash_op_valid}, 3'h7);
    check(flash_op, op);
    check(flash_addr, a - 24'(a % unit));
    for (int n = 0; n < 2000 && busy === 1'h1; n++) begin
      ticks += int'(osc_tick);
      if (flash_word_we === 1'h1) begin
        // a word write targets its own slot, a row walks 0..63 in order
        idx = (exp_we == 1) ? a[6:1] : 6'(wes);
        check(flash_word_idx, idx);
        check(flash_word, exp_word(idx));
        wes++;
      end
      @(posedge ref_clk);
      #1;
    end
    check({busy, core_stall}, 2'h0);
    check(ticks >= 23 && ticks <= 25, 1'h1);
    check(wes, exp_we);
    @(posedge ref_clk);
    #1 check(flash_control_reg[15], 1'h0);
    @(posedge ref_clk);
  endtask : run_op

  task automatic complete_run();
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // reset, refusals, then one of each operation kind
  initial begin
    reset_n = 1'h0;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    #1 check({flash_control_reg, busy, core_stall}, 18'h0_0000);
    @(posedge ref_clk);
    refused(8'h00, 8'h00);
    refused(8'hAA, 8'h55);
    load_row(24'h00_0180);
    run_op(fsps_pkg::OP_ROW_WRITE, 24'h00_01A0, fsps_pkg::ROW_BYTES, 64);
    refused(8'h00, 8'h00);
    run_op(fsps_pkg::OP_WORD_WRITE, 24'h00_0C0A, 2, 1);
    run_op(fsps_pkg::OP_PAGE_ERASE, 24'h00_0C40, fsps_pkg::PAGE_BYTES, 0);
    complete_run();
  end
endmodule : test_fsps_seq
